// ---- design/drss_refresh_sync.v ----
// refresh clock selection, fetch marker, sync stretch, arbitration
// assumes bus pins asynchronous to clk; cycle_done from delay-line timing
`include "drss_defs.vh"

module drss_refresh_sync (
   // clock and reset
   input  wire       clk,
   input  wire       sys_rst,
   // bus pins
   input  wire       phi1_pin,
   input  wire       phi2_pin,
   input  wire       sync_pin,
   input  wire       fetch_pin,
   input  wire       memr_pin,
   input  wire       write_pin,
   // configuration
   input  wire [1:0] refresh_clock_select,
   input  wire       refresh_clock_from_marker,
   input  wire       clock_delay_option_first,
   input  wire       clock_delay_option_second,
   input  wire       phi2_polarity_select,
   input  wire       sync_stretch_on_rise,
   input  wire [1:0] trigger_select,
   input  wire       unqualified_sync_trigger_option,
   input  wire [1:0] wait_state_select,
   input  wire       slow_parts,
   // memory timing
   input  wire       board_select,
   input  wire       cycle_done,
   // status and control outputs
   output reg        delayed_fetch_marker,
   output reg        stretched_sync,
   output reg        delayed_sync_copy,
   output reg        refresh_request,
   output reg        external_request,
   output reg        refresh_grant,
   output reg        external_grant,
   output reg        wait_request,
   output reg        row_strobe_n
);

   // =========================================
   // arbiter states
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_REF  = 2'h1;
   localparam [1:0] ST_EXT  = 2'h2;

   localparam [`DRSS_WR_HOLD_W-1:0] HOLD_FAST = `DRSS_WR_HOLD_FAST_CYC;
   localparam [`DRSS_WR_HOLD_W-1:0] HOLD_SLOW = `DRSS_WR_HOLD_SLOW_CYC;

   // =========================================
   // pin synchronisers
   reg  [5:0] pin_meta;
   reg  [5:0] pin_sync;
   reg  [5:0] pin_prev;
   wire [5:0] pins = {write_pin, memr_pin, fetch_pin, sync_pin, phi2_pin, phi1_pin};

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_meta <= 6'h00;
         pin_sync <= 6'h00;
         pin_prev <= 6'h00;
      end else begin
         pin_meta <= pins;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   wire sync_s  = pin_sync[2];
   wire fetch_s = pin_sync[3];
   wire memr_s  = pin_sync[4];
   wire write_s = pin_sync[5];
   wire [5:0] rise = pin_sync & ~pin_prev;
   wire [5:0] fall = ~pin_sync & pin_prev;

   // =========================================
   // fetch marker flop
   // selected phi2 edge
   wire marker_edge = phi2_polarity_select ? rise[1] : fall[1];
   reg  marker_prev;

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         delayed_fetch_marker <= 1'b0;
         marker_prev          <= 1'b0;
      end else begin
         // marker tracks fetch one phi2 edge late
         if (marker_edge) begin
            delayed_fetch_marker <= fetch_s;
         end
         marker_prev <= delayed_fetch_marker;
      end
   end

   wire marker_rise = delayed_fetch_marker & ~marker_prev;
   wire marker_fall = ~delayed_fetch_marker & marker_prev;

   // =========================================
   // stretched sync
   wire stretch_end = sync_stretch_on_rise ? rise[1] : fall[1];
   reg  sync_seen;

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stretched_sync <= 1'b0;
         sync_seen      <= 1'b0;
      end else begin
         // set at sync start, held after
         if (sync_s) begin
            stretched_sync <= 1'b1;
            sync_seen      <= 1'b1;
         // first selected phi2 edge ends it
         end else if (sync_seen && stretch_end) begin
            stretched_sync <= 1'b0;
            sync_seen      <= 1'b0;
         end
      end
   end

   // =========================================
   // delayed sync copy
   reg [`DRSS_SYNC_DLY_W-1:0] sync_shift;

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_shift        <= {`DRSS_SYNC_DLY_W{1'b0}};
         delayed_sync_copy <= 1'b0;
      end else begin
         sync_shift        <= {sync_shift[`DRSS_SYNC_DLY_W-2:0], sync_s};
         delayed_sync_copy <= |sync_shift;
      end
   end

   // =========================================
   // refresh clock selection and delay
   reg src_edge;

   // choosing legal combination is left to config
   always @* begin
      case (refresh_clock_select)
         `DRSS_RCLK_PHI2_FALL: src_edge = fall[1];
         `DRSS_RCLK_PHI1_FALL: src_edge = fall[0];
         `DRSS_RCLK_PHI1_RISE: src_edge = rise[0];
         `DRSS_RCLK_PHI2_RISE: src_edge = rise[1];
         default:              src_edge = fall[1];
      endcase
      if (refresh_clock_from_marker) begin
         src_edge = marker_fall;
      end
   end

   reg [`DRSS_DLY_W-1:0] dly_line;

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dly_line <= {`DRSS_DLY_W{1'b0}};
      end else begin
         dly_line <= {dly_line[`DRSS_DLY_W-2:0], src_edge};
      end
   end

   wire count_edge = clock_delay_option_second ? dly_line[`DRSS_DLY_SECOND_CYC-1] :
                     clock_delay_option_first  ? dly_line[`DRSS_DLY_FIRST_CYC-1]  :
                                                 src_edge;

   // =========================================
   // refresh counter
   reg [`DRSS_REF_CNT_W-1:0] refresh_counter;
   // frozen around sync and stretched sync
   wire count_en = ~(sync_s | stretched_sync | delayed_sync_copy);
   wire ref_wrap = count_en & count_edge & (refresh_counter == `DRSS_REF_CNT_LAST);
   reg  ref_done;

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         refresh_counter <= `DRSS_REF_CNT_RST;
      end else if (count_en && count_edge) begin
         refresh_counter <= refresh_counter + 1'b1;
      end
   end

   // =========================================
   // external trigger
   reg trig;

   // only the selected source can trigger; code 3 gives no trigger
   always @* begin
      case (trigger_select)
         `DRSS_TRIG_MARKER:    trig = marker_rise;
         `DRSS_TRIG_SYNC:      trig = rise[2] & unqualified_sync_trigger_option;
         `DRSS_TRIG_SYNC_MEMR: trig = rise[2] & memr_s;
         default:              trig = 1'b0;
      endcase
   end

   wire ext_trig = trig & board_select;
   reg  ext_done;

   // =========================================
   // pending requests, set wins over clear
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         refresh_request  <= 1'b0;
         external_request <= 1'b0;
      end else begin
         if (ref_wrap) begin
            refresh_request <= 1'b1;
         end else if (ref_done) begin
            refresh_request <= 1'b0;
         end
         if (ext_trig) begin
            external_request <= 1'b1;
         end else if (ext_done) begin
            external_request <= 1'b0;
         end
      end
   end

   // =========================================
   // arbiter
   reg [1:0] state;
   reg [1:0] next_state;

   always @* begin
      next_state = state;
      ref_done   = 1'b0;
      ext_done   = 1'b0;
      case (state)
         ST_IDLE: begin
            if (refresh_request) begin
               next_state = ST_REF;
            end else if (external_request) begin
               next_state = ST_EXT;
            end
         end
         ST_REF: begin
            if (cycle_done) begin
               ref_done   = 1'b1;
               next_state = ST_IDLE;
            end
         end
         ST_EXT: begin
            if (cycle_done) begin
               ext_done   = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state          <= ST_IDLE;
         refresh_grant  <= 1'b0;
         external_grant <= 1'b0;
      end else begin
         state          <= next_state;
         refresh_grant  <= (next_state == ST_REF);
         external_grant <= (next_state == ST_EXT);
      end
   end

   // =========================================
   // wait request
   reg stretch_wait;

   always @* begin
      case (wait_state_select)
         `DRSS_WAIT_ANY:   stretch_wait = stretched_sync & board_select;
         `DRSS_WAIT_FETCH: stretch_wait = stretched_sync & board_select & delayed_fetch_marker;
         `DRSS_WAIT_NONE:  stretch_wait = 1'b0;
         default:          stretch_wait = 1'b0;
      endcase
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wait_request <= 1'b0;
      end else begin
         wait_request <= stretch_wait | ((next_state == ST_REF) & (external_request | ext_trig));
      end
   end

   // =========================================
   // row strobe with write hold
   reg [`DRSS_WR_HOLD_W-1:0] hold_cnt;
   reg                       write_prev_s;
   wire                      wr_start = write_s & ~write_prev_s & ~row_strobe_n;

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hold_cnt     <= {`DRSS_WR_HOLD_W{1'b0}};
         write_prev_s <= 1'b0;
         row_strobe_n <= 1'b1;
      end else begin
         write_prev_s <= write_s;
         if (wr_start) begin
            hold_cnt <= slow_parts ? HOLD_SLOW : HOLD_FAST;
         end else if (hold_cnt != {`DRSS_WR_HOLD_W{1'b0}}) begin
            hold_cnt <= hold_cnt - 1'b1;
         end
         row_strobe_n <= ~((next_state == ST_EXT) |
                           (external_grant & stretched_sync) | wr_start |
                           (hold_cnt > {{(`DRSS_WR_HOLD_W-1){1'b0}}, 1'b1}));
      end
   end

endmodule

// ---- design/drss_defs.vh ----
// constants for the refresh clock and sync stretch block
// assumes a 100 MHz system clock and bus pins sampled by it
`ifndef DRSS_DEFS_VH
`define DRSS_DEFS_VH

// system clock period
`define DRSS_CLK_PERIOD_NS 10

// row strobe hold after write strobe start
`define DRSS_WR_HOLD_FAST_NS 70
`define DRSS_WR_HOLD_SLOW_NS 85
// cycle counts rounded up from the hold times above
`define DRSS_WR_HOLD_FAST_CYC 4'h7
`define DRSS_WR_HOLD_SLOW_CYC 4'h9
`define DRSS_WR_HOLD_W 4

// refresh counter: request on each wrap
`define DRSS_REF_CNT_W 7
`define DRSS_REF_CNT_RST 7'h00
`define DRSS_REF_CNT_LAST 7'h7F

// delay stages for the selected refresh clock, in cycles
`define DRSS_DLY_FIRST_CYC 2
`define DRSS_DLY_SECOND_CYC 4
`define DRSS_DLY_W 6

// length of the delayed sync copy, in cycles
`define DRSS_SYNC_DLY_W 8

// refresh clock source codes
`define DRSS_RCLK_PHI2_FALL 2'h0
`define DRSS_RCLK_PHI1_FALL 2'h1
`define DRSS_RCLK_PHI1_RISE 2'h2
`define DRSS_RCLK_PHI2_RISE 2'h3

// wait state selection codes
`define DRSS_WAIT_ANY 2'h0
`define DRSS_WAIT_FETCH 2'h1
`define DRSS_WAIT_NONE 2'h2

// external trigger source codes
`define DRSS_TRIG_MARKER 2'h0
`define DRSS_TRIG_SYNC 2'h1
`define DRSS_TRIG_SYNC_MEMR 2'h2

`endif

// ---- test/drss_checker_asserts.sv ----
// checker for the refresh clock and sync stretch block
// assumes bus pins are asynchronous and sampled by clk
module drss_checker (
   // clock and reset
   input logic       clk,
   input logic       sys_rst,
   // bus pins
   input logic       phi1_pin,
   input logic       phi2_pin,
   input logic       sync_pin,
   input logic       fetch_pin,
   input logic       memr_pin,
   input logic       write_pin,
   // configuration
   input logic [1:0] refresh_clock_select,
   input logic       refresh_clock_from_marker,
   input logic       clock_delay_option_first,
   input logic       clock_delay_option_second,
   input logic       phi2_polarity_select,
   input logic       sync_stretch_on_rise,
   input logic [1:0] trigger_select,
   input logic       unqualified_sync_trigger_option,
   input logic [1:0] wait_state_select,
   input logic       slow_parts,
   // memory timing
   input logic       board_select,
   input logic       cycle_done,
   // block outputs
   input logic       delayed_fetch_marker,
   input logic       stretched_sync,
   input logic       delayed_sync_copy,
   input logic       refresh_request,
   input logic       external_request,
   input logic       refresh_grant,
   input logic       external_grant,
   input logic       wait_request,
   input logic       row_strobe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // assertions
   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   AST_STRETCH_RISE: assert property ($rose(sync_pin) |-> ##[1:4] stretched_sync)
      else $error("stretch late");
   // bound allows two sync flops and a full phi2 period
   AST_STRETCH_END: assert property ($fell(sync_pin) |-> ##[1:24] !stretched_sync)
      else $error("stretch stuck");
   AST_FREEZE: assert property ($rose(refresh_request) |-> !$past(stretched_sync) && !$past(delayed_sync_copy))
      else $error("refresh while frozen");
   AST_ONE_GRANT: assert property (!(refresh_grant && external_grant))
      else $error("double grant");
   AST_TIE: assert property (refresh_request && !refresh_grant && !external_grant |=> refresh_grant)
      else $error("refresh not granted");
   AST_ARB_WAIT: assert property (refresh_grant && external_request && !cycle_done |=> wait_request)
      else $error("no arbitration wait");
   AST_EXT_STROBE: assert property ($rose(external_grant) |-> ##[0:1] !row_strobe_n)
      else $error("strobe missing");
   // strobe state is judged where the synced write edge is seen
   AST_WR_HOLD: assert property (($rose(write_pin) && !slow_parts) ##2 !row_strobe_n |=> !row_strobe_n [*7])
      else $error("strobe hold short");
   AST_WR_HOLD_SLOW: assert property (($rose(write_pin) && slow_parts) ##2 !row_strobe_n |=> !row_strobe_n [*8])
      else $error("slow hold short");
endmodule

bind drss_refresh_sync drss_checker i_chk (.*);

// ---- test/drss_bus_master.sv ----
// bus master model: phase clocks, sync, status and a late write strobe
// assumes the bench pulses go for one clk cycle while busy is low
module drss_bus_master (
   // bench command
   input  logic clk,
   input  logic go,
   input  logic is_fetch,
   input  logic is_write,
   input  logic sync_hold,
   input  logic wait_request,
   // bus pins
   output logic phi1_pin,
   output logic phi2_pin,
   output logic sync_pin,
   output logic fetch_pin,
   output logic memr_pin,
   output logic write_pin,
   output logic busy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic sync_r = 1'b0;
   assign phi1_pin = ~phi2_pin;
   assign sync_pin = sync_r | sync_hold;
   // offset keeps phi edges off clk edges
   initial begin
      {phi2_pin, fetch_pin, memr_pin, write_pin, busy} = 5'h00;
      #3.1;
      forever #62.5 phi2_pin = ~phi2_pin;
   end
   always begin
      @(posedge clk);
      if (go) begin
         busy = 1'b1;
         @(posedge phi1_pin);
         sync_r = 1'b1;
         fetch_pin = is_fetch;
         memr_pin = ~is_write;
         @(posedge phi1_pin);
         sync_r = 1'b0;
         @(posedge phi2_pin);
         write_pin = is_write;
         do @(negedge phi2_pin); while (wait_request);
         @(posedge phi2_pin);
         {fetch_pin, memr_pin, write_pin} = 3'h0;
         repeat (2) @(posedge phi2_pin);
         busy = 1'b0;
      end
   end
endmodule

// ---- test/tb.sv ----
// self-checking bench for the refresh clock and sync stretch block
// assumes the bus master model drives the pins; cycle_done comes from here
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // stimulus and observed signals
   logic        clk = 1'b0, sys_rst = 1'b1, go = 1'b0, clr = 1'b0, is_fetch = 1'b0, is_write = 1'b0;
   logic        sync_hold = 1'b0, cycle_done = 1'b0, req_d = 1'b0, busy, board_select = 1'b0;
   logic        refresh_clock_from_marker = 1'b0, clock_delay_option_first = 1'b0, clock_delay_option_second = 1'b0;
   logic [1:0]  refresh_clock_select = 2'h0, trigger_select = 2'h0, wait_state_select = 2'h0;
   logic        phi2_polarity_select = 1'b0, sync_stretch_on_rise = 1'b0, slow_parts = 1'b0;
   logic        unqualified_sync_trigger_option = 1'b0;
   logic        phi1_pin, phi2_pin, sync_pin, fetch_pin, memr_pin, write_pin;
   logic        delayed_fetch_marker, stretched_sync, delayed_sync_copy, refresh_request;
   logic        external_request, refresh_grant, external_grant, wait_request, row_strobe_n;
   logic [3:0]  seen = 4'h0;
   logic [5:0]  gcnt = 6'h00;
   int          mismatches = 0, checked = 0, n;
   // {ext, wait, marker, strobe} {trigger, wait mode} {uq, pol, slow, rise} {0, fetch, write, board}
   logic [15:0] tbl [15] = '{16'hD681, 16'h9981, 16'hBA85, 16'h0880, 16'hF085, 16'hF0D5, 16'h4081,
                             16'hD481, 16'h4401, 16'h4883, 16'hD881, 16'h4C81, 16'hF985, 16'hD4B3, 16'hD483};

   drss_refresh_sync i_dut (.*);
   drss_bus_master i_bus (.*);

   always #5 clk = ~clk;

   // grants last long enough to cover a late write strobe
   always @(posedge clk) begin
      gcnt <= (refresh_grant | external_grant) ? gcnt + 6'h01 : 6'h00;
      cycle_done <= gcnt == 6'h26;
      req_d <= refresh_request;
      seen <= clr ? 4'h0 : seen | {external_request, wait_request, delayed_fetch_marker, !row_strobe_n};
   end

   // ==========
   // tasks
   task automatic check(input string nm, input logic [15:0] sv, ev);
      checked++;
      if (sv !== ev) begin
         mismatches++;
         $display("MISMATCH %s expected %0h seen %0h", nm, ev, sv);
      end
   endtask

   task automatic stop_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic hang(input int k, lim);
      if (k >= lim) begin
         mismatches++;
         stop_test();
      end
   endtask

   task automatic req_gap(input int lim, input bit must, output int k);
      for (k = 0; k < lim; k++) begin
         @(negedge clk);
         if (refresh_request && !req_d) break;
      end
      if (must) hang(k, lim);
   endtask

   task automatic run(input logic [15:0] t);
      @(posedge clk);
      {trigger_select, wait_state_select} <= t[11:8];
      {unqualified_sync_trigger_option, phi2_polarity_select, slow_parts, sync_stretch_on_rise} <= t[7:4];
      {is_fetch, is_write, board_select} <= t[2:0];
      {go, clr} <= 2'h3;
      @(posedge clk);
      {go, clr} <= 2'h0;
      for (n = 0; n < 300; n++) begin
         @(negedge clk);
         if (!busy) break;
      end
      hang(n, 300);
      repeat (40) @(negedge clk);
      check("bus cycle", seen, t[15:12]);
   endtask

   // ==========
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      // first entry lands on a fresh refresh grant
      req_gap(4000, 1'b1, n);
      foreach (tbl[i]) run(tbl[i]);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         refresh_clock_select <= i[1:0];
         {clock_delay_option_second, clock_delay_option_first} <= i[1:0];
         req_gap(4000, 1'b1, n);
         req_gap(4000, 1'b1, n);
         check("refresh gap", n > 1596 && n < 1604, 1'b1);
      end
      @(posedge clk);
      sync_hold <= 1'b1;
      req_gap(2500, 1'b0, n);
      check("frozen gap", 16'(n), 16'h09C4);
      @(posedge clk);
      sync_hold <= 1'b0;
      req_gap(4000, 1'b1, n);
      check("resumed gap", n > 1596 && n < 1650, 1'b1);
      @(posedge clk);
      refresh_clock_from_marker <= 1'b1;
      req_gap(2500, 1'b0, n);
      check("marker gap", 16'(n), 16'h09C4);
      stop_test();
   end
endmodule
